// ===== design/cph_pkg.sv
// package for the camera process-data handshake controller
// assumes one 40 MHz core clock and an APB slave for software
package cph_pkg;
    // apb register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] HOIST_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] RES0_OFS = 8'h0C;
    localparam logic [7:0] RES1_OFS = 8'h10;
    // control register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_ENA_BIT = 1;
    localparam int CTRL_SEL_LSB = 4;
    // data identifiers
    localparam logic [7:0] ID_CODE_INFO = 8'h09;
    localparam logic [7:0] ID_RESULT = 8'h81;
    // sequence values
    localparam logic [7:0] SEQ_END = 8'h00;
    localparam logic [7:0] SEQ_VALID = 8'h01;
    // net length sent in bytes 2 and 3
    localparam logic [15:0] NET_LEN = 16'h0004;
    // camera error bit positions in its byte 5
    localparam int ERR_IMPAIRED = 3;
    localparam int ERR_NO_REFL = 4;
    localparam int ERR_DIST = 5;
    // code change timeout, 15 s plus margin
    localparam int CLK_MHZ = 40;
    localparam int CHG_MAX_MS = 16000;
    localparam int CHG_MAX_CYC = CHG_MAX_MS * 1000 * CLK_MHZ;
    localparam logic [7:0] ZERO8 = 8'h00;

    // buffer the controller sends to the camera
    typedef struct packed {
        logic [7:0] seq_echo;
        logic [15:0] net_len;
        logic [7:0] req_id;
        logic [31:0] hoist_mm;
    } cph_out_t;

    // discrete control lines to the camera
    typedef struct packed {
        logic processing_enable;
        logic teach_request;
        logic trigger_input;
        logic clear_line;
        logic [3:0] code_choice;
    } cph_ctl_t;

    // code selection states
    typedef enum logic [1:0] {
        SEL_IDLE = 2'b00,
        SEL_WAIT_LOW = 2'b01,
        SEL_WAIT_HIGH = 2'b10
    } cph_sel_t;
endpackage : cph_pkg

// ===== design/cph_ctrl.sv
// controller driving the camera process-data handshake and code select
// assumes camera inputs are asynchronous; software uses apb
// Behaviour
// R1: byte 1 carries echoed packet number
// R2: bytes 2-3 carry net length
// R3: byte 4 carries requested data identifier
// R4: bytes 5-8 carry signed hoist millimetres
// R5: id 09 returns code and control status
// R6: camera waits for confirmation before next
// R7: echo camera byte 1 into byte 1
// R8: camera sequence 0 ends transfer
// R9: camera sequence 1 means data valid
// R10: on 1 echo 1, request id 81
// R11: camera closes with sequence 0
// R12: on 0 echo 0, request id 81
// R13: four select bits choose codes 1-15
// R14: code 0 keeps previous code
// R15: enable high, teach trigger clear low
// R16: change start drops done and ready
// R17: done and ready rise when finished
// R18: stop state: set enable to start
// R19: ready high means processing mode
// R20: camera byte 4 names supplied data
// R21: camera byte 5 holds error bits
// R22: hold select and enable during change
`timescale 1ns/100ps
module cph_ctrl #(
    parameter int CHG_TIMEOUT = cph_pkg::CHG_MAX_CYC
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // camera buffer, camera to controller
    input wire logic [7:0] CAM_SEQ,
    input wire logic [7:0] CAM_ID,
    input wire logic [7:0] CAM_ERR,
    // camera discrete status
    input wire logic CODE_CHANGE_DONE,
    input wire logic CAM_READY,
    input wire logic OPERATING_STATE,
    // controller buffer and control lines to the camera
    output cph_pkg::cph_out_t CAM_OUT,
    output cph_pkg::cph_ctl_t CAM_CTL
);
    logic run_ff;
    logic ena_ff;
    logic [3:0] sel_ff;
    logic [31:0] hoist_ff;
    logic [7:0] seq_s1_ff, seq_ff, id_s1_ff, id_ff, err_s1_ff, err_ff;
    logic [2:0] st_s1_ff, st_ff;
    logic [7:0] echo_ff;
    logic [7:0] last_id_ff;
    logic [7:0] last_err_ff;
    logic [15:0] pkt_cnt_ff;
    cph_pkg::cph_sel_t sel_st_ff, nxt_sel_st;
    logic [3:0] out_code_ff;
    logic chg_busy, chg_tmo_ff;
    logic [31:0] tmo_cnt_ff;
    logic chg_expired;
    logic [31:0] ctrl_rd;
    logic [3:0] pend_code_ff;
    logic wr, rd;
    logic done_s, rdy_s, op_s;

    // apb strobes, true in the access phase only
    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && PENABLE && !PWRITE;
    // synchronised camera status bits
    assign done_s = st_ff[2];
    assign rdy_s = st_ff[1];
    assign op_s = st_ff[0];

    // two-flop synchronisers for camera inputs
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            seq_s1_ff <= cph_pkg::ZERO8;
            seq_ff <= cph_pkg::ZERO8;
            id_s1_ff <= cph_pkg::ZERO8;
            id_ff <= cph_pkg::ZERO8;
            err_s1_ff <= cph_pkg::ZERO8;
            err_ff <= cph_pkg::ZERO8;
            st_s1_ff <= 3'h0;
            st_ff <= 3'h0;
        end else begin
            seq_s1_ff <= CAM_SEQ;
            seq_ff <= seq_s1_ff;
            id_s1_ff <= CAM_ID;
            id_ff <= id_s1_ff;
            err_s1_ff <= CAM_ERR;
            err_ff <= err_s1_ff;
            st_s1_ff <= {CODE_CHANGE_DONE, CAM_READY, OPERATING_STATE};
            st_ff <= st_s1_ff;
        end
    end

    // software control registers
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            run_ff <= 1'b0;
            ena_ff <= 1'b0;
            sel_ff <= 4'h0;
            hoist_ff <= 32'h0;
        end else if (wr && PADDR == cph_pkg::CTRL_OFS) begin
            run_ff <= PWDATA[cph_pkg::CTRL_RUN_BIT];
            ena_ff <= PWDATA[cph_pkg::CTRL_ENA_BIT];
            sel_ff <= PWDATA[cph_pkg::CTRL_SEL_LSB +: 4];
        end else if (wr && PADDR == cph_pkg::HOIST_OFS) begin
            hoist_ff <= PWDATA; // see R4
        end
    end

    // sequence echo: copy camera number once it is 0 or 1
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            echo_ff <= cph_pkg::SEQ_END;
            pkt_cnt_ff <= 16'h0;
            last_id_ff <= cph_pkg::ZERO8;
            last_err_ff <= cph_pkg::ZERO8;
        end else if (run_ff && seq_ff != echo_ff &&
                     (seq_ff == cph_pkg::SEQ_VALID ||
                      seq_ff == cph_pkg::SEQ_END)) begin
            echo_ff <= seq_ff; // see R7, R10, R12
            if (seq_ff == cph_pkg::SEQ_VALID) begin // see R9
                pkt_cnt_ff <= pkt_cnt_ff + 16'h1;
                last_id_ff <= id_ff; // see R20
                last_err_ff <= err_ff; // see R21
            end
        end
    end

    // outgoing buffer always asks for a result frame
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            CAM_OUT <= '0;
        end else begin
            CAM_OUT.seq_echo <= echo_ff; // see R1
            CAM_OUT.net_len <= cph_pkg::NET_LEN; // see R2
            CAM_OUT.req_id <= cph_pkg::ID_RESULT; // see R3, R10, R12
            CAM_OUT.hoist_mm <= hoist_ff; // see R4
        end
    end

    // code selection sequencer
    always_comb begin
        nxt_sel_st = sel_st_ff;
        unique case (sel_st_ff)
            cph_pkg::SEL_IDLE: begin
                if (ena_ff && sel_ff != 4'h0 && sel_ff != out_code_ff)
                    nxt_sel_st = cph_pkg::SEL_WAIT_LOW;
            end
            cph_pkg::SEL_WAIT_LOW: begin
                if (!done_s && !rdy_s) // see R16
                    nxt_sel_st = cph_pkg::SEL_WAIT_HIGH;
                else if (chg_expired)
                    nxt_sel_st = cph_pkg::SEL_IDLE;
            end
            cph_pkg::SEL_WAIT_HIGH: begin
                if ((done_s && rdy_s) || chg_expired) // see R17
                    nxt_sel_st = cph_pkg::SEL_IDLE;
            end
            default: nxt_sel_st = cph_pkg::SEL_IDLE;
        endcase
    end

    assign chg_busy = sel_st_ff != cph_pkg::SEL_IDLE;
    // per-change expiry, so a past timeout cannot abort a later change
    assign chg_expired = tmo_cnt_ff == 32'(CHG_TIMEOUT);

    // control register read-back, fields where a write puts them
    always_comb begin
        ctrl_rd = 32'h0;
        ctrl_rd[cph_pkg::CTRL_RUN_BIT] = run_ff;
        ctrl_rd[cph_pkg::CTRL_ENA_BIT] = ena_ff;
        ctrl_rd[cph_pkg::CTRL_SEL_LSB +: 4] = sel_ff;
    end

    // state register, and held code that is frozen while a change runs
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sel_st_ff <= cph_pkg::SEL_IDLE;
            out_code_ff <= 4'h0;
            pend_code_ff <= 4'h0;
        end else begin
            sel_st_ff <= nxt_sel_st;
            if (!chg_busy && nxt_sel_st == cph_pkg::SEL_WAIT_LOW) begin
                out_code_ff <= sel_ff; // see R13, R22
                pend_code_ff <= sel_ff;
            end
        end
    end

    // timeout guard on a code change
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tmo_cnt_ff <= 32'h0;
            chg_tmo_ff <= 1'b0;
        end else if (!chg_busy) begin
            tmo_cnt_ff <= 32'h0;
        end else if (chg_expired) begin
            chg_tmo_ff <= 1'b1;
        end else begin
            tmo_cnt_ff <= tmo_cnt_ff + 32'h1;
        end
    end

    // discrete lines; enable starts processing from stop
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            CAM_CTL <= '0;
        end else begin
            CAM_CTL.processing_enable <= ena_ff || chg_busy; // see R15, R18
            CAM_CTL.teach_request <= 1'b0; // see R15
            CAM_CTL.trigger_input <= 1'b0;
            CAM_CTL.clear_line <= 1'b0;
            CAM_CTL.code_choice <= chg_busy ? pend_code_ff : 4'h0; // see R14
        end
    end

    // apb read data, zero-wait answers
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= 32'h0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            unique case (PADDR)
                cph_pkg::CTRL_OFS: PRDATA <= ctrl_rd;
                cph_pkg::HOIST_OFS: PRDATA <= hoist_ff;
                cph_pkg::STAT_OFS:
                    PRDATA <= {pkt_cnt_ff, 4'h0, out_code_ff, chg_tmo_ff,
                               chg_busy, op_s && !rdy_s, rdy_s, done_s,
                               op_s, echo_ff[0], seq_ff[0]}; // see R19
                cph_pkg::RES0_OFS: PRDATA <= {16'h0, last_id_ff, last_err_ff};
                default: PRDATA <= 32'h0;
            endcase
        end
    end

    // zero wait states; offsets past the last register answer an error
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && PADDR > cph_pkg::RES0_OFS;

    // echo follows a stable camera number within a few cycles
    a_echo_follows: assert property ( // see R10
        @(posedge CORE_CLK) disable iff (!RST_N)
        run_ff && $stable(seq_ff) && seq_ff == cph_pkg::SEQ_VALID
        |-> ##[1:3] CAM_OUT.seq_echo == cph_pkg::SEQ_VALID)
        else $error("echo did not follow sequence 1");
    a_echo_zero: assert property ( // see R12
        @(posedge CORE_CLK) disable iff (!RST_N)
        run_ff && $stable(seq_ff) && seq_ff == cph_pkg::SEQ_END
        |-> ##[1:3] CAM_OUT.seq_echo == cph_pkg::SEQ_END)
        else $error("echo did not follow sequence 0");
    // a packet is counted only when the echo turns to 1
    a_count_valid: assert property ( // see R7
        @(posedge CORE_CLK) disable iff (!RST_N)
        $changed(pkt_cnt_ff) |-> $rose(echo_ff[0]))
        else $error("packet counted without a new echo");
    // fixed length and id fields and the forwarded hoist, checked from the first edge out of reset
    a_id_result: assert property ( // see R12
        @(posedge CORE_CLK) disable iff (!RST_N)
        RST_N |=> CAM_OUT.req_id == cph_pkg::ID_RESULT)
        else $error("request id not result frame");
    a_len_const: assert property ( // see R2
        @(posedge CORE_CLK) disable iff (!RST_N)
        RST_N |=> CAM_OUT.net_len == cph_pkg::NET_LEN)
        else $error("net length wrong");
    a_hoist_out: assert property ( // see R4
        @(posedge CORE_CLK) disable iff (!RST_N)
        RST_N |=> CAM_OUT.hoist_mm == $past(hoist_ff))
        else $error("hoist position not forwarded");
    // discrete control lines and the code select pattern
    a_lines_low: assert property ( // see R15
        @(posedge CORE_CLK) disable iff (!RST_N)
        !CAM_CTL.teach_request && !CAM_CTL.trigger_input
        && !CAM_CTL.clear_line)
        else $error("teach trigger or clear raised");
    a_enable_level: assert property ( // see R18
        @(posedge CORE_CLK) disable iff (!RST_N)
        ena_ff |=> CAM_CTL.processing_enable)
        else $error("processing enable not driven");
    a_sel_hold: assert property ( // see R22
        @(posedge CORE_CLK) disable iff (!RST_N)
        chg_busy && $past(chg_busy) && $past(chg_busy, 2)
        |-> $stable(CAM_CTL.code_choice) && CAM_CTL.processing_enable)
        else $error("select changed during code change");
    a_code_out: assert property ( // see R13
        @(posedge CORE_CLK) disable iff (!RST_N)
        chg_busy && $past(chg_busy)
        |-> CAM_CTL.code_choice == out_code_ff && out_code_ff != 4'h0)
        else $error("code lines differ from the held code");
    a_idle_zero: assert property ( // see R14
        @(posedge CORE_CLK) disable iff (!RST_N)
        !chg_busy && !$past(chg_busy) |-> ##1 CAM_CTL.code_choice == 4'h0)
        else $error("code lines not zero while idle");
    a_start_nonzero: assert property ( // see R13
        @(posedge CORE_CLK) disable iff (!RST_N)
        $rose(chg_busy) |-> out_code_ff != 4'h0)
        else $error("code change with code zero");
    // a change ends only on done and ready, or once the sticky timeout flag is set by any expiry since reset
    a_busy_exit: assert property ( // see R17
        @(posedge CORE_CLK) disable iff (!RST_N)
        $fell(chg_busy) |-> ($past(done_s) && $past(rdy_s)) || chg_tmo_ff)
        else $error("code change left without done and ready");
    a_tmo_sticky: assert property ( // see R17
        @(posedge CORE_CLK) disable iff (!RST_N)
        chg_tmo_ff |=> chg_tmo_ff)
        else $error("timeout flag cleared without reset");
endmodule : cph_ctrl

// ===== bench/cph_cam_model.sv
// camera model: packet sequence handshake, code change and ready status
// assumes the controller drives its buffer and lines on clk
`timescale 1ns/100ps
module cph_cam_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // controller side
    input cph_pkg::cph_out_t cam_out,
    input cph_pkg::cph_ctl_t cam_ctl,
    // bench knobs
    input wire logic pause,
    input wire logic [15:0] chg_cyc,
    input wire logic [7:0] err_in,
    // camera outputs
    output logic [7:0] seq_ff,
    output logic [7:0] id_ff,
    output logic [7:0] err_ff,
    output logic done_ff,
    output logic ready,
    output logic op_state
);
    logic [3:0] code_ff;
    logic [15:0] cnt_ff;
    logic [1:0] lat_ff;
    // a new packet only once the echo confirms the last one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_ff <= 8'h00;
            id_ff <= 8'h00;
            err_ff <= 8'h00;
            lat_ff <= 2'h0;
        end else if (pause || cam_out.seq_echo !== seq_ff) begin
            lat_ff <= 2'h0;
        end else if (lat_ff != 2'h3) begin
            lat_ff <= lat_ff + 2'h1;
        end else begin
            seq_ff <= {7'h00, ~seq_ff[0]};
            id_ff <= cam_out.req_id;
            // a code-info request is answered with the code number
            err_ff <= (cam_out.req_id == cph_pkg::ID_CODE_INFO) ?
                      {4'h0, code_ff} : err_in;
        end
    end
    // code change drops done, raises it chg_cyc+1 cycles later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_ff <= 4'h0;
            cnt_ff <= 16'h0000;
            done_ff <= 1'b1;
        end else if (done_ff && cam_ctl.code_choice != 4'h0 &&
                     cam_ctl.code_choice != code_ff) begin
            done_ff <= 1'b0;
            code_ff <= cam_ctl.code_choice;
            cnt_ff <= chg_cyc;
        end else if (!done_ff && cnt_ff != 16'h0000) begin
            cnt_ff <= cnt_ff - 16'h0001;
        end else begin
            done_ff <= 1'b1;
        end
    end
    // ready follows done and enable; always in operation
    assign ready = done_ff && cam_ctl.processing_enable;
    assign op_state = 1'b1;
endmodule : cph_cam_model

// ===== bench/tb_top.sv
// testbench for the handshake controller with a camera model
// assumes apb answers within a few cycles
`timescale 1ns/100ps
module tb_top;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, pause;
    logic [7:0] paddr, cam_seq, cam_id, cam_err, err_in;
    logic [31:0] pwdata, prdata, rdata;
    logic [15:0] chg_cyc;
    logic rerr, done, rdy, op;
    cph_pkg::cph_out_t cam_out;
    cph_pkg::cph_ctl_t cam_ctl;
    int error_cnt = 0;
    int check_count = 0;
    cph_ctrl #(.CHG_TIMEOUT(50)) DUT (.CORE_CLK(clk), .RST_N(rst_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CAM_SEQ(cam_seq), .CAM_ID(cam_id),
        .CAM_ERR(cam_err), .CODE_CHANGE_DONE(done), .CAM_READY(rdy),
        .OPERATING_STATE(op), .CAM_OUT(cam_out), .CAM_CTL(cam_ctl));
    cph_cam_model cam (.clk(clk), .rst_n(rst_n), .cam_out(cam_out),
        .cam_ctl(cam_ctl), .pause(pause), .chg_cyc(chg_cyc),
        .err_in(err_in), .seq_ff(cam_seq), .id_ff(cam_id),
        .err_ff(cam_err), .done_ff(done), .ready(rdy), .op_state(op));
    // clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic print_verdict;
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk(32'h1, 32'h0);
            print_verdict();
        end
    endtask : apb
    task automatic poll(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] v);
        int k;
        k = 0;
        do begin
            apb(1'b0, a, 32'h0);
            k++;
        end while ((rdata & m) !== v && k < 100);
        chk(rdata & m, v);
        if ((rdata & m) !== v) print_verdict();
    endtask : poll
    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, pause} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        chg_cyc = 16'h0014;
        err_in = 8'h38;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        chk(cam_out.req_id, cph_pkg::ID_RESULT);
        chk(cam_out.net_len, cph_pkg::NET_LEN);
        chk({cam_ctl.teach_request, cam_ctl.trigger_input,
             cam_ctl.clear_line}, 32'h0);
        apb(1'b1, cph_pkg::HOIST_OFS, 32'hFFFFFB2E);
        repeat (2) @(negedge clk);
        chk(cam_out.hoist_mm, 32'hFFFFFB2E);
        apb(1'b0, cph_pkg::HOIST_OFS, 32'h0);
        chk(rdata, 32'hFFFFFB2E);
        apb(1'b0, cph_pkg::RES1_OFS, 32'h0);
        chk(rerr, 32'h1);
        apb(1'b0, cph_pkg::STAT_OFS, 32'h0);
        chk(rdata[5:4], 32'h2);
        apb(1'b1, cph_pkg::CTRL_OFS, 32'h00000003);
        poll(cph_pkg::STAT_OFS, 32'h30, 32'h10);
        repeat (100) @(negedge clk);
        apb(1'b0, cph_pkg::STAT_OFS, 32'h0);
        chk(rdata[31:16] >= 16'h0002, 32'h1);
        pause <= 1'b1;
        repeat (12) @(negedge clk);
        chk(cam_out.seq_echo, cam_seq);
        apb(1'b1, cph_pkg::CTRL_OFS, 32'h00000002);
        pause <= 1'b0;
        repeat (20) @(negedge clk);
        chk(cam_out.seq_echo, {7'h00, ~cam_seq[0]});
        apb(1'b0, cph_pkg::RES0_OFS, 32'h0);
        chk(rdata[15:0], {cph_pkg::ID_RESULT, 8'h38});
        apb(1'b1, cph_pkg::CTRL_OFS, 32'h000000B3);
        repeat (3) @(negedge clk);
        chk(cam_ctl.code_choice, 32'hB);
        chk(cam_ctl.processing_enable, 32'h1);
        apb(1'b0, cph_pkg::CTRL_OFS, 32'h0);
        chk(rdata, 32'h000000B3);
        poll(cph_pkg::STAT_OFS, 32'hF40, 32'hB00);
        chk(cam_ctl.code_choice, 32'h0);
        apb(1'b1, cph_pkg::CTRL_OFS, 32'h00000003);
        chg_cyc <= 16'h00C8;
        repeat (5) @(negedge clk);
        chk(cam_ctl.code_choice, 32'h0);
        apb(1'b1, cph_pkg::CTRL_OFS, 32'h00000053);
        poll(cph_pkg::STAT_OFS, 32'h80, 32'h80);
        print_verdict();
    end
endmodule : tb_top
